// File: rtl/kdsc_pkg.sv
// Package for the keyboard and display scan controller.
// Assumes a single 200 MHz system clock and synchronous host strobes.
package kdsc_pkg;

  // ==========================================================
  // Clock and timing
  localparam int unsigned CLK_MHZ          = 200;
  localparam int unsigned SCAN_TICK_US     = 10;    // One scan step
  localparam int unsigned DEBOUNCE_US      = 10300;
  localparam int unsigned PRESCALE_RESET   = 31;
  localparam int unsigned PRESCALE_MIN     = 2;
  // Row timing in prescaled ticks; debounce in full scans
  localparam int unsigned SCAN_STEP_TICKS  = 8;     // Internal cycles/row
  localparam int unsigned DEBOUNCE_SCANS   = 2;     // Full scans to recheck
  localparam int unsigned BLANK_TICKS      = 2;     // Blank within each row

  // ==========================================================
  // Command opcodes, bits 7..5 of a command byte
  localparam logic [2:0] OP_MODE    = 3'h0;
  localparam logic [2:0] OP_CLOCK   = 3'h1;
  localparam logic [2:0] OP_RDFIFO  = 3'h2;
  localparam logic [2:0] OP_RDDISP  = 3'h3;
  localparam logic [2:0] OP_WRDISP  = 3'h4;
  localparam logic [2:0] OP_INHBLK  = 3'h5;
  localparam logic [2:0] OP_CLEAR   = 3'h6;
  localparam logic [2:0] OP_ENDINT  = 3'h7;

  // ==========================================================
  // Field positions
  localparam int unsigned AUTO_INC_POS = 4;
  localparam int unsigned E_BIT_POS    = 4;
  localparam int unsigned CF_POS       = 1;
  localparam int unsigned CA_POS       = 0;
  localparam int unsigned IW_HI_POS    = 3;
  localparam int unsigned IW_LO_POS    = 2;
  localparam int unsigned BL_HI_POS    = 1;
  localparam int unsigned BL_LO_POS    = 0;

  // ==========================================================
  // Reset values
  localparam logic [1:0] DISP_MODE_RESET = 2'h1;  // 16 char, left entry
  localparam logic [2:0] KEY_MODE_RESET  = 3'h0;
  localparam logic [7:0] CLEAR_VAL_2016  = 8'h20;
  localparam logic [7:0] CLEAR_VAL_ONES  = 8'hff;
  localparam logic [7:0] CLEAR_VAL_ZERO  = 8'h00;

  typedef enum logic [1:0] {
    KD_LOCKOUT = 2'b00,
    KD_ROLLOVER = 2'b01,
    KD_SENSOR  = 2'b10,
    KD_STROBED = 2'b11
  } kdsc_kmode_e;

  typedef enum logic [0:0] {
    RS_FIFO = 1'b0,
    RS_DISP = 1'b1
  } kdsc_rsel_e;

  // Host access decoded into one bundle
  typedef struct packed {
    logic       wr_cmd;
    logic       wr_data;
    logic       rd_data;
    logic [7:0] wdata;
  } kdsc_host_s;

endpackage

// File: rtl/kdsc_ram.sv
// Small synchronous RAM with registered read data and bit write mask.
// Assumes one clock; write and read may happen in the same cycle.
`timescale 1ns/1ps
module kdsc_ram #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 16,
  parameter int unsigned AW    = 4
) (
  input  wire logic             clk_i,
  input  wire logic             we_i,
  input  wire logic [AW-1:0]    waddr_i,
  input  wire logic [WIDTH-1:0] wdata_i,
  input  wire logic [WIDTH-1:0] wmask_i,
  input  wire logic [AW-1:0]    raddr_i,
  output logic      [WIDTH-1:0] rdata_o
);

  logic [WIDTH-1:0] mem [DEPTH];

  // ==========================================================
  // Storage; no reset so it maps onto plain RAM cells
  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem[waddr_i] <= (mem[waddr_i] & ~wmask_i) | (wdata_i & wmask_i);
    end
    rdata_o <= mem[raddr_i];
  end

endmodule

// File: rtl/kdsc_top.sv
// Keyboard and display scan controller: host port, timing, scan, FIFO.
// Assumes host strobes are synchronous to CLOCK_I and held >= 2 cycles.
`timescale 1ns/1ps

module kdsc_top (
  input  wire logic       CLOCK_I,
  input  wire logic       RST_N_I,
  input  wire logic       RESET_I,
  input  wire logic       CS_N_I,
  input  wire logic       BUF_ADDR_SEL_I,
  input  wire logic       RD_N_I,
  input  wire logic       WR_N_I,
  input  wire logic [7:0] DATA_I,
  output logic      [7:0] DATA_O,
  output logic            DATA_OE_O,
  output logic            IRQ_O,
  output logic      [3:0] SCAN_OUT_O,
  input  wire logic [7:0] RETURN_IN_I,
  input  wire logic       SHIFT_I,
  input  wire logic       CTL_STROBE_IN_I,
  output logic      [3:0] DIGIT_PORT_HI_O,
  output logic      [3:0] DIGIT_PORT_LO_O,
  output logic            BLANK_OUT_O
);

  typedef struct packed {
    logic [4:0] prescale_field;
    logic [4:0] pre_cnt;
    logic [2:0] step_cnt;
    logic [3:0] scan_cnt;
    logic [1:0] disp_mode;
    logic [2:0] key_mode;
    logic [3:0] disp_addr;
    logic       disp_auto;
    logic [2:0] row_ptr;
    logic       row_auto;
    logic       rd_sel;
    logic       inhibit_write_hi;
    logic       inhibit_write_lo;
    logic       blank_hi;
    logic       blank_lo;
    logic       clearing;
    logic [7:0] clear_val;
    logic [4:0] clear_left;
    logic [2:0] wr_ptr;
    logic [2:0] rd_ptr;
    logic [3:0] queue_cnt;
    logic       overrun;
    logic       underrun;
    logic       sensor_err;
    logic       sensor_irq;
    logic       sensor_lock;
    logic       err_mode;
    logic [5:0] deb_key;
    logic       deb_busy;
    logic [1:0] deb_scans;
    logic [1:0] wr_sync;
    logic [1:0] rd_sync;
    logic       stb_last;
    logic [7:0] data_out;
  } kdsc_state_s;

  kdsc_state_s st_reg;
  kdsc_state_s st_next;
  kdsc_pkg::kdsc_host_s host;

  logic       tick;
  logic       step_end;
  logic       fifo_full;
  logic       fifo_empty;
  logic       push;
  logic [7:0] push_data;
  logic       blank_phase;
  logic       dram_we;
  logic [3:0] dram_waddr;
  logic [7:0] dram_wdata;
  logic [7:0] dram_wmask;
  logic [7:0] dram_rdata;
  logic       qram_we;
  logic [2:0] qram_waddr;
  logic [7:0] qram_wdata;
  logic [7:0] qram_rdata;
  logic [2:0] qram_raddr;
  logic       rd_fall;
  logic       wr_rise;
  logic       any_key;
  logic [2:0] key_col;
  logic [3:0] disp_rd_addr;
  logic       sense_scan;

  // ==========================================================
  // Helpers
  function automatic logic [2:0] lowest_low(input logic [7:0] v);
    lowest_low = 3'h0;
    for (int i = 7; i >= 0; i--) begin
      if (!v[i]) begin
        lowest_low = i[2:0];
      end
    end
  endfunction

  function automatic logic [3:0] scan_drive(input logic [3:0] cnt,
                                            input logic       dec);
    scan_drive = dec ? ~(4'h1 << cnt[1:0]) : cnt;
  endfunction

  // ==========================================================
  // Host strobe decode; writes act on the trailing edge
  assign wr_rise = ~st_reg.wr_sync[1] & st_reg.wr_sync[0];
  assign rd_fall = st_reg.rd_sync[1] & ~st_reg.rd_sync[0];
  always_comb begin
    host.wr_cmd  = wr_rise & ~CS_N_I & BUF_ADDR_SEL_I;
    host.wr_data = wr_rise & ~CS_N_I & ~BUF_ADDR_SEL_I;
    host.rd_data = rd_fall & ~CS_N_I & ~BUF_ADDR_SEL_I;
    host.wdata   = DATA_I;
  end

  // Bus driven only while selected and reading
  assign DATA_OE_O = ~CS_N_I & ~RD_N_I;
  assign DATA_O    = st_reg.data_out;

  // ==========================================================
  // Timing chain: prescaler, row step, scan counter
  assign tick     = (st_reg.pre_cnt == 5'h01);
  assign step_end = tick &
    (st_reg.step_cnt == 3'(kdsc_pkg::SCAN_STEP_TICKS - 1));
  assign blank_phase =
    (st_reg.step_cnt < 3'(kdsc_pkg::BLANK_TICKS));

  assign fifo_full  = (st_reg.queue_cnt == 4'h8);
  assign fifo_empty = (st_reg.queue_cnt == 4'h0);
  assign any_key    = (RETURN_IN_I != 8'hff);
  assign key_col    = lowest_low(RETURN_IN_I);
  // Sensor rows are fetched for change checks only while no read is in
  // flight, so a host read always sees the row it pointed at
  assign sense_scan = (st_reg.key_mode[2:1] == kdsc_pkg::KD_SENSOR) &
                      RD_N_I & (st_reg.step_cnt == 3'h7);
  assign qram_raddr = sense_scan ? st_reg.scan_cnt[2:0] :
                      (st_reg.key_mode[2:1] == kdsc_pkg::KD_SENSOR) ?
                      st_reg.row_ptr : st_reg.rd_ptr;
  // Refresh keeps the scan address except during a display read
  assign disp_rd_addr =
    (st_reg.rd_sel == kdsc_pkg::RS_DISP && !RD_N_I) ?
    st_reg.disp_addr : st_reg.scan_cnt;

  // ==========================================================
  // Next-state logic for the whole block
  always_comb begin
    logic        dec;
    logic [1:0]  km;
    logic [3:0]  last_digit;
    logic        sens_set;
    logic        ovr_set;
    dec        = 1'b0;
    sens_set   = 1'b0;
    ovr_set    = 1'b0;
    km         = 2'b00;
    last_digit = 4'h0;
    st_next    = st_reg;
    push       = 1'b0;
    push_data  = 8'h00;
    qram_we    = 1'b0;
    qram_waddr = st_reg.wr_ptr;
    qram_wdata = 8'h00;
    dram_we    = 1'b0;
    dram_waddr = st_reg.disp_addr;
    dram_wdata = host.wdata;
    dram_wmask = 8'hff;
    km         = st_reg.key_mode[2:1];
    dec        = st_reg.key_mode[0];
    last_digit = st_reg.disp_mode[0] ? 4'hf : 4'h7;

    st_next.wr_sync  = {st_reg.wr_sync[0], WR_N_I};
    st_next.rd_sync  = {st_reg.rd_sync[0], RD_N_I};
    st_next.stb_last = CTL_STROBE_IN_I;

    // Prescaler divides the system clock by the programmed field
    st_next.pre_cnt = tick ? st_reg.prescale_field : st_reg.pre_cnt - 5'h01;
    if (tick) begin
      st_next.step_cnt = st_reg.step_cnt + 3'h1;
    end
    if (step_end) begin
      st_next.scan_cnt = (st_reg.scan_cnt == last_digit) ? 4'h0 :
                         st_reg.scan_cnt + 4'h1;
    end

    // Keyboard and sensor sampling at row end; strobe sampling on its rising edge
    // A row is only updated when its old value was fetched last cycle;
    // a row skipped under a host read is caught on the next scan
    if (step_end && km == kdsc_pkg::KD_SENSOR && !st_reg.sensor_lock &&
        st_reg.scan_cnt[3] == 1'b0 && st_reg.rd_sync[0]) begin
      qram_we    = 1'b1;
      qram_waddr = st_reg.scan_cnt[2:0];
      qram_wdata = RETURN_IN_I;
      if (qram_rdata != RETURN_IN_I) begin
        sens_set           = 1'b1;
        st_next.sensor_irq = 1'b1;
      end
    end
    if (step_end && (km == kdsc_pkg::KD_LOCKOUT ||
                     km == kdsc_pkg::KD_ROLLOVER) &&
        st_reg.scan_cnt[3] == 1'b0) begin
      if (!st_reg.deb_busy && any_key) begin
        st_next.deb_busy  = 1'b1;
        st_next.deb_key   = {st_reg.scan_cnt[2:0], key_col};
        st_next.deb_scans = 2'h0;
      end else if (st_reg.deb_busy &&
                   st_reg.deb_key[5:3] == st_reg.scan_cnt[2:0]) begin
        if (st_reg.deb_scans ==
            2'(kdsc_pkg::DEBOUNCE_SCANS - 1)) begin
          st_next.deb_busy = 1'b0;
          if (!RETURN_IN_I[st_reg.deb_key[2:0]]) begin
            push      = 1'b1;
            push_data = {CTL_STROBE_IN_I, SHIFT_I, st_reg.deb_key};
          end
        end else begin
          st_next.deb_scans = st_reg.deb_scans + 2'h1;
        end
      end
    end
    if (km == kdsc_pkg::KD_STROBED && CTL_STROBE_IN_I && !st_reg.stb_last)
    begin
      push      = 1'b1;
      push_data = RETURN_IN_I;
    end

    // FIFO push with overrun on full
    if (push) begin
      if (fifo_full) begin
        ovr_set         = 1'b1;
        st_next.overrun = 1'b1;
      end else begin
        qram_we          = 1'b1;
        qram_waddr       = st_reg.wr_ptr;
        qram_wdata       = push_data;
        st_next.wr_ptr   = st_reg.wr_ptr + 3'h1;
        st_next.queue_cnt = st_reg.queue_cnt + 4'h1;
      end
    end

    // Display clear steps one word per scan row, so it spans 16 scan rows
    if (st_reg.clearing) begin
      dram_we    = 1'b1;
      dram_waddr = st_reg.clear_left[3:0];
      dram_wdata = st_reg.clear_val;
      dram_wmask = 8'hff;
      if (step_end) begin
        st_next.clear_left = st_reg.clear_left - 5'h01;
        if (st_reg.clear_left == 5'h00) begin
          st_next.clearing = 1'b0;
        end
      end
    end

    // Host data read: FIFO or display RAM by the latest read command
    if (host.rd_data) begin
      if (st_reg.rd_sel == kdsc_pkg::RS_DISP) begin
        st_next.data_out = dram_rdata;
        if (st_reg.disp_auto) begin
          st_next.disp_addr = st_reg.disp_addr + 4'h1;
        end
      end else begin
        st_next.data_out = qram_rdata;
        if (km == kdsc_pkg::KD_SENSOR) begin
          if (st_reg.row_auto) begin
            st_next.row_ptr = st_reg.row_ptr + 3'h1;
          end
        end else if (fifo_empty) begin
          st_next.underrun = 1'b1;
        end else begin
          st_next.rd_ptr    = st_reg.rd_ptr + 3'h1;
          st_next.queue_cnt = st_next.queue_cnt - 4'h1;
        end
      end
    end else if (rd_fall && !CS_N_I) begin
      st_next.data_out = {st_reg.clearing,
                          st_reg.sensor_err | st_reg.err_mode,
                          st_reg.overrun, st_reg.underrun,
                          fifo_full, st_reg.queue_cnt[2:0]};
    end

    // Host data write into display RAM, refused while clearing
    if (host.wr_data && !st_reg.clearing) begin
      dram_we    = 1'b1;
      dram_waddr = st_reg.disp_addr;
      dram_wdata = host.wdata;
      dram_wmask = {{4{~st_reg.inhibit_write_hi}},
                    {4{~st_reg.inhibit_write_lo}}};
      if (st_reg.disp_auto) begin
        st_next.disp_addr = st_reg.disp_addr + 4'h1;
      end
    end

    // Command decode
    if (host.wr_cmd) begin
      case (host.wdata[7:5])
        kdsc_pkg::OP_MODE: begin
          st_next.disp_mode = host.wdata[4:3];
          st_next.key_mode  = host.wdata[2:0];
        end
        kdsc_pkg::OP_CLOCK: begin
          if (host.wdata[4:0] >= 5'(kdsc_pkg::PRESCALE_MIN)) begin
            st_next.prescale_field = host.wdata[4:0];
          end
        end
        kdsc_pkg::OP_RDFIFO: begin
          st_next.rd_sel   = kdsc_pkg::RS_FIFO;
          st_next.row_auto = host.wdata[kdsc_pkg::AUTO_INC_POS];
          st_next.row_ptr  = host.wdata[2:0];
        end
        kdsc_pkg::OP_RDDISP, kdsc_pkg::OP_WRDISP: begin
          st_next.rd_sel    = (host.wdata[7:5] == kdsc_pkg::OP_RDDISP) ?
                              kdsc_pkg::RS_DISP : st_reg.rd_sel;
          st_next.disp_auto = host.wdata[kdsc_pkg::AUTO_INC_POS];
          st_next.disp_addr = host.wdata[3:0];
        end
        kdsc_pkg::OP_INHBLK: begin
          st_next.inhibit_write_hi = host.wdata[kdsc_pkg::IW_HI_POS];
          st_next.inhibit_write_lo = host.wdata[kdsc_pkg::IW_LO_POS];
          st_next.blank_hi         = host.wdata[kdsc_pkg::BL_HI_POS];
          st_next.blank_lo         = host.wdata[kdsc_pkg::BL_LO_POS];
        end
        kdsc_pkg::OP_CLEAR: begin
          st_next.clear_val = !host.wdata[3] ? kdsc_pkg::CLEAR_VAL_ZERO :
            (host.wdata[2] ? kdsc_pkg::CLEAR_VAL_ONES :
                             kdsc_pkg::CLEAR_VAL_2016);
          if (host.wdata[4] || host.wdata[kdsc_pkg::CA_POS]) begin
            st_next.clearing   = 1'b1;
            st_next.clear_left = 5'h0f;
          end
          if (host.wdata[kdsc_pkg::CF_POS] ||
              host.wdata[kdsc_pkg::CA_POS]) begin
            st_next.wr_ptr     = 3'h0;
            st_next.rd_ptr     = 3'h0;
            st_next.queue_cnt  = 4'h0;
            st_next.row_ptr    = 3'h0;
            st_next.sensor_irq = sens_set;  // Same-cycle event wins
            st_next.overrun    = ovr_set;
            st_next.underrun   = 1'b0;
          end
          if (host.wdata[kdsc_pkg::CA_POS]) begin
            st_next.pre_cnt  = st_reg.prescale_field;
            st_next.step_cnt = 3'h0;
            st_next.scan_cnt = 4'h0;
            st_next.deb_busy = 1'b0;
          end
        end
        kdsc_pkg::OP_ENDINT: begin
          st_next.sensor_irq  = sens_set;
          st_next.sensor_lock = 1'b0;
          st_next.sensor_err  = 1'b0;
          st_next.err_mode = host.wdata[kdsc_pkg::E_BIT_POS] &&
                             km == kdsc_pkg::KD_ROLLOVER;
        end
        default: begin
          st_next.key_mode = st_reg.key_mode;
        end
      endcase
    end

    // A pending sensor change blocks further sensor RAM writes
    if (st_next.sensor_irq) begin
      st_next.sensor_lock = 1'b1;
    end
  end

  // ==========================================================
  // Reset: async low pin plus synchronous high reset input
  always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      st_reg <= '0;
      st_reg.prescale_field <= 5'(kdsc_pkg::PRESCALE_RESET);
      st_reg.disp_mode      <= kdsc_pkg::DISP_MODE_RESET;
      st_reg.key_mode       <= kdsc_pkg::KEY_MODE_RESET;
      st_reg.wr_sync        <= 2'h3;
      st_reg.rd_sync        <= 2'h3;
      st_reg.stb_last       <= 1'b1;  // Idle pulled-up level, no false edge
    end else if (RESET_I) begin
      st_reg <= '0;
      st_reg.prescale_field <= 5'(kdsc_pkg::PRESCALE_RESET);
      st_reg.disp_mode      <= kdsc_pkg::DISP_MODE_RESET;
      st_reg.key_mode       <= kdsc_pkg::KEY_MODE_RESET;
      st_reg.wr_sync        <= 2'h3;
      st_reg.rd_sync        <= 2'h3;
      st_reg.stb_last       <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  // ==========================================================
  // Outputs
  assign SCAN_OUT_O = scan_drive(st_reg.scan_cnt, st_reg.key_mode[0]);
  assign IRQ_O = (st_reg.key_mode[2:1] == kdsc_pkg::KD_SENSOR) ?
                 st_reg.sensor_irq : ~fifo_empty;
  assign BLANK_OUT_O = blank_phase |
                       (st_reg.blank_hi & st_reg.blank_lo);
  assign DIGIT_PORT_HI_O = (blank_phase | st_reg.blank_hi) ? 4'h0 :
                           dram_rdata[7:4];
  assign DIGIT_PORT_LO_O = (blank_phase | st_reg.blank_lo) ? 4'h0 :
                           dram_rdata[3:0];

  // ==========================================================
  // Memories: display RAM and FIFO/sensor RAM
  kdsc_ram #(.WIDTH(8), .DEPTH(16), .AW(4)) u_disp (
    .clk_i   (CLOCK_I),
    .we_i    (dram_we),
    .waddr_i (dram_waddr),
    .wdata_i (dram_wdata),
    .wmask_i (dram_wmask),
    .raddr_i (disp_rd_addr),
    .rdata_o (dram_rdata)
  );

  kdsc_ram #(.WIDTH(8), .DEPTH(8), .AW(3)) u_queue (
    .clk_i   (CLOCK_I),
    .we_i    (qram_we),
    .waddr_i (qram_waddr),
    .wdata_i (qram_wdata),
    .wmask_i (8'hff),
    .raddr_i (qram_raddr),
    .rdata_o (qram_rdata)
  );

  // ==========================================================
  // Checks
  a_bus_release: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
    CS_N_I |-> !DATA_OE_O) else $error("bus driven while deselected");
  a_irq_queue: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
    (st_reg.key_mode[2:1] != kdsc_pkg::KD_SENSOR) |->
    (IRQ_O == (st_reg.queue_cnt != 4'h0))) else $error("irq vs queue");
  a_count_bound: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
    st_reg.queue_cnt <= 4'h8) else $error("queue count too big");
  a_prescale_ok: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
    st_reg.prescale_field >= 5'h02) else $error("prescale low");
  a_clear_len: assert property (@(posedge CLOCK_I)
    disable iff (!RST_N_I || RESET_I)
    $rose(st_reg.clearing) |-> st_reg.clearing [*8])
    else $error("clear too short");
  a_overrun_set: assert property (@(posedge CLOCK_I)
    disable iff (!RST_N_I || RESET_I)
    (push && fifo_full && !host.wr_cmd) |=> st_reg.overrun)
    else $error("overrun missed");
  a_dec_scan: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
    st_reg.key_mode[0] |-> $countones(~SCAN_OUT_O) == 1)
    else $error("decoded scan not one-hot");
  a_write_refused: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
    (st_reg.clearing) |-> (dram_wdata == st_reg.clear_val))
    else $error("host write during clear");

endmodule

// File: verification/kdsc_host_model.sv
// Host processor model driving the parallel bus of the scan controller.
// Assumes bus inputs are sampled on rising edges of clk_i.
`timescale 1ns/1ps
module kdsc_host_model (
  input  wire logic       clk_i,
  input  wire logic [7:0] rdata_i,
  output logic            cs_n_o,
  output logic            a0_o,
  output logic            rd_n_o,
  output logic            wr_n_o,
  output logic      [7:0] wdata_o
);
  // ==========================================================
  // Idle bus
  initial begin
    cs_n_o  = 1'b1;
    a0_o    = 1'b0;
    rd_n_o  = 1'b1;
    wr_n_o  = 1'b1;
    wdata_o = 8'h00;
  end

  // Write: strobe low 3 cycles, qualifiers held past the take edge
  task automatic wr(input logic a0, input logic [7:0] d);
    @(posedge clk_i);
    cs_n_o  <= 1'b0;
    a0_o    <= a0;
    wdata_o <= d;
    wr_n_o  <= 1'b0;
    repeat (3) @(posedge clk_i);
    wr_n_o  <= 1'b1;
    repeat (3) @(posedge clk_i);
    cs_n_o  <= 1'b1;
    wdata_o <= ~d; // Released bus must not show the old byte
    repeat (3) @(posedge clk_i);
  endtask

  // Read: data taken at the edge before the strobe is released
  task automatic rd(input logic a0, output logic [7:0] d);
    @(posedge clk_i);
    cs_n_o <= 1'b0;
    a0_o   <= a0;
    rd_n_o <= 1'b0;
    repeat (4) @(posedge clk_i);
    d = rdata_i;
    rd_n_o <= 1'b1;
    cs_n_o <= 1'b1;
    repeat (3) @(posedge clk_i);
  endtask
endmodule

// File: verification/tb_kdsc_top.sv
// Self-checking bench for the scan controller through its host bus.
// Assumes the host model sits on the bus; reset input pulsed once in the reset test.
`timescale 1ns/1ps
module tb_kdsc_top;
  logic       clk = 1'b0;
  logic       rst_n = 1'b0;
  logic       stb = 1'b1;
  logic [7:0] ret = 8'hff;
  logic [7:0] rdata, wdata, rv;
  logic       oe, irq, cs_n, a0, rd_n, wr_n;
  logic       rst_pin = 1'b0;
  logic       blank;
  logic [3:0] scan, dhi, dlo;
  int         n_errors = 0;
  int         cmp_count = 0;

  // ==========================================================
  // Clock, design and host
  always #2.5 clk = ~clk;
  kdsc_top u_kdsc_top (.CLOCK_I(clk), .RST_N_I(rst_n), .RESET_I(rst_pin),
    .CS_N_I(cs_n), .BUF_ADDR_SEL_I(a0), .RD_N_I(rd_n), .WR_N_I(wr_n),
    .DATA_I(wdata), .DATA_O(rdata), .DATA_OE_O(oe), .IRQ_O(irq),
    .SCAN_OUT_O(scan), .RETURN_IN_I(ret), .SHIFT_I(1'b1),
    .CTL_STROBE_IN_I(stb), .DIGIT_PORT_HI_O(dhi), .DIGIT_PORT_LO_O(dlo),
    .BLANK_OUT_O(blank));
  kdsc_host_model u_kdsc_host_model (.clk_i(clk), .rdata_i(rdata),
    .cs_n_o(cs_n), .a0_o(a0), .rd_n_o(rd_n), .wr_n_o(wr_n),
    .wdata_o(wdata));

  // ==========================================================
  // Helpers
  task automatic check(input string what, input logic [7:0] seen, exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Strobed entry: rising edge of the strobe queues the return lines
  task automatic push(input logic [7:0] d);
    @(posedge clk);
    stb <= 1'b0;
    ret <= d;
    repeat (4) @(posedge clk);
    stb <= 1'b1;
    repeat (4) @(posedge clk);
  endtask

  task automatic stop_test();
    $display("Comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Watchdog far above the few thousand cycles the tests need
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    stop_test();
  end

  // ==========================================================
  // Tests
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    u_kdsc_host_model.rd(1'b1, rv);
    check("status", rv, 8'h00);
    check("oe", {7'h0, oe}, 8'h00);
    u_kdsc_host_model.wr(1'b1, 8'h90);
    u_kdsc_host_model.wr(1'b0, 8'h12);
    u_kdsc_host_model.wr(1'b0, 8'h34);
    u_kdsc_host_model.wr(1'b1, 8'ha8);
    u_kdsc_host_model.wr(1'b1, 8'h80);
    u_kdsc_host_model.wr(1'b0, 8'hff);
    u_kdsc_host_model.wr(1'b1, 8'ha0);
    u_kdsc_host_model.wr(1'b1, 8'h70);
    u_kdsc_host_model.rd(1'b0, rv);
    check("disp0", rv, 8'h1f);
    u_kdsc_host_model.rd(1'b0, rv);
    check("disp1", rv, 8'h34);
    u_kdsc_host_model.wr(1'b1, 8'ha3);
    check("blank", {7'h0, blank}, 8'h01);
    check("digits", {dhi, dlo}, 8'h00);
    u_kdsc_host_model.wr(1'b1, 8'ha0);
    $display("test display done");
    u_kdsc_host_model.wr(1'b1, 8'h06);
    push(8'ha5);
    check("irq", {7'h0, irq}, 8'h01);
    u_kdsc_host_model.rd(1'b1, rv);
    check("status", rv, 8'h01);
    u_kdsc_host_model.wr(1'b1, 8'h40);
    u_kdsc_host_model.rd(1'b0, rv);
    check("fifo", rv, 8'ha5);
    check("irq", {7'h0, irq}, 8'h00);
    u_kdsc_host_model.rd(1'b0, rv);
    u_kdsc_host_model.rd(1'b1, rv);
    check("under", rv & 8'h17, 8'h10);
    for (int i = 0; i < 9; i++) begin
      push(8'(i));
    end
    u_kdsc_host_model.rd(1'b1, rv);
    check("over", rv & 8'h2f, 8'h28);
    u_kdsc_host_model.wr(1'b1, 8'hc2);
    check("irq", {7'h0, irq}, 8'h00);
    $display("test fifo done");
    u_kdsc_host_model.wr(1'b1, 8'hdc);
    u_kdsc_host_model.rd(1'b1, rv);
    check("unavail", rv & 8'h80, 8'h80);
    // The display clear at the reset prescaler spans 16 rows of 248 cycles
    repeat (4300) @(posedge clk);
    u_kdsc_host_model.rd(1'b1, rv);
    check("avail", rv & 8'h80, 8'h00);
    u_kdsc_host_model.wr(1'b1, 8'h70);
    u_kdsc_host_model.rd(1'b0, rv);
    check("clear", rv, 8'hff);
    $display("test clear done");
    u_kdsc_host_model.wr(1'b1, 8'h07);
    check("scan", 8'($countones(scan)), 8'h03);
    push(8'h3c);
    rst_pin <= 1'b1;
    repeat (2) @(posedge clk);
    rst_pin <= 1'b0;
    u_kdsc_host_model.rd(1'b1, rv);
    check("reset", rv, 8'h00);
    check("irq", {7'h0, irq}, 8'h00);
    $display("test reset done");
    // Fast prescaler, 8 digits, lockout; clear-all aligns row 0
    u_kdsc_host_model.wr(1'b1, 8'h22);
    u_kdsc_host_model.wr(1'b1, 8'h00);
    ret <= 8'hfb;
    u_kdsc_host_model.wr(1'b1, 8'hc1);
    repeat (380) @(posedge clk);
    ret <= 8'hff;
    u_kdsc_host_model.wr(1'b1, 8'h40);
    u_kdsc_host_model.rd(1'b0, rv);
    check("key", rv, 8'hc2);
    $display("test keyboard done");
    stop_test();
  end
endmodule
